// ### spdsr_pkg.sv
// Package: register map, field positions and state codes of the serial port
package spdsr_pkg;
  // Register offsets
  localparam logic [3:0] A_RXL   = 4'h0;
  localparam logic [3:0] A_RXH   = 4'h1;
  localparam logic [3:0] A_TXL   = 4'h2;
  localparam logic [3:0] A_TXH   = 4'h3;
  localparam logic [3:0] A_STAT  = 4'h4;
  localparam logic [3:0] A_INTERRUPT_AND_MODE_CONTROL = 4'h5;
  localparam logic [3:0] A_RX_TX_ENABLE_CONTROL = 4'h6;
  localparam logic [3:0] A_FRAME_FORMAT_CONTROL = 4'h7;
  localparam logic [3:0] A_BAUDL = 4'h8;
  localparam logic [3:0] A_BAUDH = 4'h9;
  localparam logic [3:0] A_AUTOBAUD_WINDOW_CONTROL = 4'hA;
  localparam logic [3:0] A_DBG   = 4'hB;
  localparam logic [3:0] A_EVC   = 4'hC;
  localparam logic [3:0] A_TXPL  = 4'hD;
  localparam logic [3:0] A_RXPL  = 4'hE;
  // Writable-bit masks, reserved bits stay zero
  localparam logic [7:0] M_RX_TX_ENABLE_CONTROL = 8'hDF;
  localparam logic [7:0] M_AUTOBAUD_WINDOW_CONTROL = 8'hC0;
  localparam logic [7:0] M_BIT0  = 8'h01;
  localparam logic [7:0] M_RXPL  = 8'h7F;
  // Field positions
  localparam int RXCIE_B = 7;
  localparam int TXCIE_B = 6;
  localparam int DREIE_B = 5;
  localparam int LBME_B  = 3;
  localparam int RXEN_B  = 7;
  localparam int TXEN_B  = 6;
  localparam int TXC_B   = 6;
  localparam int PEN_B   = 5;
  localparam int PODD_B  = 4;
  localparam int SB2_B   = 3;
  localparam int E_FRAME_ERROR_FLAG  = 9;
  localparam int E_PARITY_ERROR_FLAG  = 10;
  // Field encodings
  localparam logic [2:0] CS_9LO    = 3'h6;
  localparam logic [1:0] CM_SPIH   = 2'h3;
  localparam logic [1:0] RXM_LIN   = 2'h3;
  localparam logic [1:0] FIFO_FULL = 2'h2;
  localparam logic [15:0] BAUD_MIN = 16'h0001;

  // Receiver states
  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_PAR   = 3'b011,
    RX_STOP  = 3'b100
  } spdsr_rx_state_t;

  // Data bits per character size code
  function automatic logic [3:0] spdsr_char_bits(input logic [2:0] cs);
    case (cs)
      3'h0:    spdsr_char_bits = 4'h5;
      3'h1:    spdsr_char_bits = 4'h6;
      3'h2:    spdsr_char_bits = 4'h7;
      3'h6:    spdsr_char_bits = 4'h9;
      3'h7:    spdsr_char_bits = 4'h9;
      default: spdsr_char_bits = 4'h8;
    endcase
  endfunction
endpackage

// ### spdsr_tx_if.sv
// Interface: transmit buffer to transmit shifter
`timescale 1ns/1ps
interface spdsr_tx_if;
  logic        load;
  logic [8:0]  data;
  logic [3:0]  nbits;
  logic        par_en;
  logic        par_odd;
  logic        two_stop;
  logic [15:0] period;
  logic        busy;
  logic        done;
  logic        txd;
  modport src (output load, data, nbits, par_en, par_odd, two_stop, period,
               input busy, done, txd);
  modport eng (input load, data, nbits, par_en, par_odd, two_stop, period,
               output busy, done, txd);
endinterface // spdsr_tx_if

// ### spdsr_tx_engine.sv
// Transmit shifter: frames one character and sends it on the line
`timescale 1ns/1ps
module spdsr_tx_engine (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  spdsr_tx_if.eng   tx
);
  localparam logic [15:0] BAUD_ONE = spdsr_pkg::BAUD_MIN;
  logic [12:0] frame;
  logic [3:0]  len;
  logic [12:0] sh_r;
  logic [3:0]  left_r;
  logic [15:0] cnt_r;
  logic        busy_r;
  logic        done_r;
  logic        par;

  // Frame image: start, data LSB first, parity, stop bits
  always_comb
  begin
    frame    = '1;
    frame[0] = 1'b0;
    par      = tx.par_odd;
    for (int i = 0; i < 9; i++)
    begin
      if (4'(i) < tx.nbits)
      begin
        frame[i + 1] = tx.data[i];
        par          = par ^ tx.data[i];
      end
    end
    if (tx.par_en)
      frame[tx.nbits + 4'h1] = par;
    len = 4'h2 + tx.nbits + {3'h0, tx.par_en} + {3'h0, tx.two_stop};
  end

  // Shift one bit per bit period
  always_ff @(posedge ref_clk_i)
  begin
    done_r <= 1'b0;
    if (rst_i)
    begin
      sh_r   <= '1;
      left_r <= 4'h0;
      cnt_r  <= 16'h0000;
      busy_r <= 1'b0;
    end
    else if (!busy_r && tx.load)
    begin
      sh_r   <= frame;
      left_r <= len;
      cnt_r  <= tx.period - BAUD_ONE;
      busy_r <= 1'b1;
    end
    else if (busy_r && cnt_r == 16'h0000)
    begin
      sh_r   <= {1'b1, sh_r[12:1]};
      left_r <= left_r - 4'h1;
      cnt_r  <= tx.period - BAUD_ONE;
      if (left_r == 4'h1)
      begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
      end
    end
    else if (busy_r)
      cnt_r <= cnt_r - BAUD_ONE;
  end

  assign tx.busy = busy_r;
  assign tx.done = done_r;
  assign tx.txd  = sh_r[0];

  property p_load_start;
    @(posedge ref_clk_i) disable iff (rst_i)
    (tx.load && !busy_r) |=> (busy_r && !tx.txd);
  endproperty
  a_load_start: assert property (p_load_start) else $error("no start bit");

  property p_end_done;
    @(posedge ref_clk_i) disable iff (rst_i)
    $fell(busy_r) |-> done_r;
  endproperty
  a_end_done: assert property (p_end_done) else $error("end without done");
endmodule // spdsr_tx_engine

// ### spdsr_top.sv
// Serial port data, status and control registers with receiver and buffers
// Summary of operation
// - Two-deep receive buffer shows oldest frame
// - Nine-bit low-first: high read advances, else low
// - Receive-complete high while buffer holds data
// - Overflow when full, frame waiting, new start
// - Reading receive data clears overflow flag
// - Frame error follows first stop bit level
// - Parity error only when enabled and wrong
// - Host SPI mode: error flags unused
// - High byte bit 0 holds ninth bit
// - LIN auto-baud: ninth bit marks response space
// - Written byte goes buffer, shifter, line
// - Nine-bit low-first: high write advances, else low
// - High byte flag positions 7,6,2,1,0
// - Transmit complete set at end with buffer empty, write-one clears
// - Data-register-empty follows transmit buffer state
// - Interrupt request while flag and enable set
`timescale 1ns/1ps
module spdsr_top (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       rxd_i,
  output logic            txd_o,
  input  wire logic       lin_pid_field_i,
  output logic            irq_rxc_o,
  output logic            irq_txc_o,
  output logic            irq_dre_o
);
  spdsr_tx_if tx_if ();

  logic [7:0]  interrupt_and_mode_control_r;
  logic [7:0]  rx_tx_enable_control_r;
  logic [7:0]  frame_format_control_r;
  logic [7:0]  autobaud_window_control_r;
  logic [7:0]  dbg_r;
  logic [7:0]  evc_r;
  logic [7:0]  txpl_r;
  logic [7:0]  rxpl_r;
  logic [15:0] baud_r;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;

  // Receive path state
  spdsr_pkg::spdsr_rx_state_t rx_st_r;
  logic [15:0] rx_cnt_r;
  logic [3:0]  rx_idx_r;
  logic [8:0]  rx_sh_r;
  logic        rx_parity_error_flag_r;
  logic        rx_prev_r;
  logic        wait_r;
  logic [10:0] wait_q_r;
  logic        ovf_r;
  logic [10:0] mem_r [2];
  logic        rd_ptr_r;
  logic [1:0]  count_r;

  // Transmit path state
  logic [7:0]  tx_lo_r;
  logic        tx_hi_r;
  logic [8:0]  buf_r;
  logic        buf_v_r;
  logic        txc_r;

  // Access decode
  wire wr_txl  = wr_i && addr_i == spdsr_pkg::A_TXL;
  wire wr_txh  = wr_i && addr_i == spdsr_pkg::A_TXH;
  wire wr_stat = wr_i && addr_i == spdsr_pkg::A_STAT;
  wire rd_rxl  = rd_i && addr_i == spdsr_pkg::A_RXL;
  wire rd_rxh  = rd_i && addr_i == spdsr_pkg::A_RXH;
  wire rd_rx   = rd_rxl || rd_rxh;

  // Mode decode
  wire        sel9lo   = frame_format_control_r[2:0] == spdsr_pkg::CS_9LO;
  wire        spi_host = frame_format_control_r[7:6] == spdsr_pkg::CM_SPIH;
  wire        lin_auto = rx_tx_enable_control_r[2:1] == spdsr_pkg::RXM_LIN;
  wire        rxen     = rx_tx_enable_control_r[spdsr_pkg::RXEN_B];
  wire        txen     = rx_tx_enable_control_r[spdsr_pkg::TXEN_B];
  wire        par_en   = frame_format_control_r[spdsr_pkg::PEN_B];
  wire        par_odd  = frame_format_control_r[spdsr_pkg::PODD_B];
  wire [3:0]  nbits    = spdsr_pkg::spdsr_char_bits(frame_format_control_r[2:0]);
  wire [15:0] period   = (baud_r == 16'h0000) ? spdsr_pkg::BAUD_MIN : baud_r;
  wire        rx_in    = interrupt_and_mode_control_r[spdsr_pkg::LBME_B] ? tx_if.txd : rxd_i;

  // Receive buffer control
  wire        rxc      = count_r != 2'h0;
  wire        full     = count_r == spdsr_pkg::FIFO_FULL;
  wire        pop      = rxc && (sel9lo ? rd_rxh : rd_rxl);
  wire        push     = wait_r && (!full || pop);
  wire        wr_idx   = rd_ptr_r ^ count_r[0];
  wire [10:0] head     = mem_r[rd_ptr_r];
  wire        tick     = rx_cnt_r == 16'h0000;
  wire        start_ev = rxen && rx_prev_r && !rx_in;
  wire        ovf_set  = start_ev && full && wait_r;
  wire        frame_ok = rx_st_r == spdsr_pkg::RX_STOP && tick;
  wire        ninth    = lin_auto ? !lin_pid_field_i : rx_sh_r[8];
  wire        rx_parity_error_flag  = par_en && (^rx_sh_r ^ rx_in ^ par_odd);

  // Transmit buffer control
  wire        adv      = !buf_v_r && (sel9lo ? wr_txh : wr_txl);
  wire        txc_set  = tx_if.done && !buf_v_r;
  wire        txc_clr  = wr_stat && wdata_i[spdsr_pkg::TXC_B];
  wire        dre      = !buf_v_r;

  // Control registers, reserved bits masked on write
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      interrupt_and_mode_control_r <= 8'h00;
      rx_tx_enable_control_r <= 8'h00;
      frame_format_control_r <= 8'h00;
      autobaud_window_control_r <= 8'h00;
      dbg_r   <= 8'h00;
      evc_r   <= 8'h00;
      txpl_r  <= 8'h00;
      rxpl_r  <= 8'h00;
      baud_r  <= 16'h0000;
    end
    else if (wr_i)
    begin
      case (addr_i)
        spdsr_pkg::A_INTERRUPT_AND_MODE_CONTROL: interrupt_and_mode_control_r <= wdata_i;
        spdsr_pkg::A_RX_TX_ENABLE_CONTROL: rx_tx_enable_control_r <= wdata_i & spdsr_pkg::M_RX_TX_ENABLE_CONTROL;
        spdsr_pkg::A_FRAME_FORMAT_CONTROL: frame_format_control_r <= wdata_i;
        spdsr_pkg::A_BAUDL: baud_r[7:0] <= wdata_i;
        spdsr_pkg::A_BAUDH: baud_r[15:8] <= wdata_i;
        spdsr_pkg::A_AUTOBAUD_WINDOW_CONTROL: autobaud_window_control_r <= wdata_i & spdsr_pkg::M_AUTOBAUD_WINDOW_CONTROL;
        spdsr_pkg::A_DBG:   dbg_r <= wdata_i & spdsr_pkg::M_BIT0;
        spdsr_pkg::A_EVC:   evc_r <= wdata_i & spdsr_pkg::M_BIT0;
        spdsr_pkg::A_TXPL:  txpl_r <= wdata_i;
        spdsr_pkg::A_RXPL:  rxpl_r <= wdata_i & spdsr_pkg::M_RXPL;
        default: ;
      endcase
    end
  end

  // Receive shift sequencer
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      rx_st_r   <= spdsr_pkg::RX_IDLE;
      rx_cnt_r  <= 16'h0000;
      rx_idx_r  <= 4'h0;
      rx_sh_r   <= 9'h000;
      rx_parity_error_flag_r <= 1'b0;
      rx_prev_r <= 1'b1;
    end
    else
    begin
      rx_prev_r <= rx_in;
      rx_cnt_r  <= tick ? period - spdsr_pkg::BAUD_MIN : rx_cnt_r - 16'h0001;
      case (rx_st_r)
        spdsr_pkg::RX_IDLE:
        begin
          if (start_ev && !(full && wait_r))
          begin
            rx_st_r   <= spdsr_pkg::RX_START;
            rx_cnt_r  <= {1'b0, period[15:1]};
            rx_idx_r  <= 4'h0;
            rx_sh_r   <= 9'h000;
            rx_parity_error_flag_r <= 1'b0;
          end
        end
        spdsr_pkg::RX_START:
        begin
          if (tick)
            rx_st_r <= rx_in ? spdsr_pkg::RX_IDLE : spdsr_pkg::RX_DATA;
        end
        spdsr_pkg::RX_DATA:
        begin
          if (tick)
          begin
            rx_sh_r[rx_idx_r] <= rx_in;
            rx_idx_r          <= rx_idx_r + 4'h1;
            if (rx_idx_r == nbits - 4'h1)
              rx_st_r <= par_en ? spdsr_pkg::RX_PAR : spdsr_pkg::RX_STOP;
          end
        end
        spdsr_pkg::RX_PAR:
        begin
          if (tick)
          begin
            rx_parity_error_flag_r <= rx_parity_error_flag;
            rx_st_r   <= spdsr_pkg::RX_STOP;
          end
        end
        spdsr_pkg::RX_STOP:
        begin
          if (tick)
            rx_st_r <= spdsr_pkg::RX_IDLE;
        end
        default: rx_st_r <= spdsr_pkg::RX_IDLE;
      endcase
      if (!rxen)
        rx_st_r <= spdsr_pkg::RX_IDLE;
    end
  end

  // Completed frame waits in the shift stage until a slot frees
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      wait_r   <= 1'b0;
      wait_q_r <= 11'h000;
    end
    else if (frame_ok && (!wait_r || push))
    begin
      wait_r   <= 1'b1;
      wait_q_r <= {rx_parity_error_flag_r, !rx_in, ninth, rx_sh_r[7:0]};
    end
    else if (push)
      wait_r <= 1'b0;
  end

  // Buffer entries, one writer per slot
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_slot
      always_ff @(posedge ref_clk_i)
      begin
        if (rst_i)
          mem_r[g] <= 11'h000;
        else if (push && wr_idx == 1'(g))
          mem_r[g] <= wait_q_r;
      end
    end
  endgenerate

  // Buffer pointers and overflow flag; a set beats a read clear
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      rd_ptr_r <= 1'b0;
      count_r  <= 2'h0;
      ovf_r    <= 1'b0;
    end
    else
    begin
      rd_ptr_r <= rd_ptr_r ^ pop;
      count_r  <= count_r + {1'b0, push} - {1'b0, pop};
      if (ovf_set)
        ovf_r <= 1'b1;
      else if (rd_rx)
        ovf_r <= 1'b0;
    end
  end

  // Transmit staging, buffer and complete flag
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      tx_lo_r <= 8'h00;
      tx_hi_r <= 1'b0;
      buf_r   <= 9'h000;
      buf_v_r <= 1'b0;
      txc_r   <= 1'b0;
    end
    else
    begin
      if (wr_txl)
        tx_lo_r <= wdata_i;
      if (wr_txh)
        tx_hi_r <= wdata_i[0];
      if (adv)
      begin
        buf_r   <= sel9lo ? {wdata_i[0], tx_lo_r} : {tx_hi_r, wdata_i};
        buf_v_r <= 1'b1;
      end
      else if (tx_if.load)
        buf_v_r <= 1'b0;
      if (txc_set)
        txc_r <= 1'b1;
      else if (txc_clr)
        txc_r <= 1'b0;
    end
  end

  // Shifter hookup
  assign tx_if.load     = buf_v_r && txen && !tx_if.busy;
  assign tx_if.data     = buf_r;
  assign tx_if.nbits    = nbits;
  assign tx_if.par_en   = par_en;
  assign tx_if.par_odd  = par_odd;
  assign tx_if.two_stop = frame_format_control_r[spdsr_pkg::SB2_B];
  assign tx_if.period   = period;

  spdsr_tx_engine u_tx (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .tx        (tx_if.eng)
  );

  // Error flags hidden in host SPI mode
  wire       e_ovf  = ovf_r && !spi_host;
  wire       e_frame_error_flag = head[spdsr_pkg::E_FRAME_ERROR_FLAG] && !spi_host;
  wire       e_parity_error_flag = head[spdsr_pkg::E_PARITY_ERROR_FLAG] && !spi_host;
  wire [7:0] rxh    = {rxc, e_ovf, 3'h0, e_frame_error_flag, e_parity_error_flag, head[8]};
  wire [7:0] stat   = {rxc, txc_r, dre, 5'h00};

  // Read multiplexer, unmapped and write-only read zero
  always_comb
  begin
    case (addr_i)
      spdsr_pkg::A_RXL:   rdata_nxt = head[7:0];
      spdsr_pkg::A_RXH:   rdata_nxt = rxh;
      spdsr_pkg::A_STAT:  rdata_nxt = stat;
      spdsr_pkg::A_INTERRUPT_AND_MODE_CONTROL: rdata_nxt = interrupt_and_mode_control_r;
      spdsr_pkg::A_RX_TX_ENABLE_CONTROL: rdata_nxt = rx_tx_enable_control_r;
      spdsr_pkg::A_FRAME_FORMAT_CONTROL: rdata_nxt = frame_format_control_r;
      spdsr_pkg::A_BAUDL: rdata_nxt = baud_r[7:0];
      spdsr_pkg::A_BAUDH: rdata_nxt = baud_r[15:8];
      spdsr_pkg::A_AUTOBAUD_WINDOW_CONTROL: rdata_nxt = autobaud_window_control_r;
      spdsr_pkg::A_DBG:   rdata_nxt = dbg_r;
      spdsr_pkg::A_EVC:   rdata_nxt = evc_r;
      spdsr_pkg::A_TXPL:  rdata_nxt = txpl_r;
      spdsr_pkg::A_RXPL:  rdata_nxt = rxpl_r;
      default:            rdata_nxt = 8'h00;
    endcase
  end

  // Read data held for the cycle after the strobe only
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      rdata_r <= 8'h00;
    else
      rdata_r <= rd_i ? rdata_nxt : 8'h00;
  end

  // Outputs; requests follow flag and enable
  assign rdata_o   = rdata_r;
  assign txd_o     = tx_if.txd;
  assign irq_rxc_o = rxc && interrupt_and_mode_control_r[spdsr_pkg::RXCIE_B];
  assign irq_txc_o = txc_r && interrupt_and_mode_control_r[spdsr_pkg::TXCIE_B];
  assign irq_dre_o = dre && interrupt_and_mode_control_r[spdsr_pkg::DREIE_B];

  property p_pop_low;
    @(posedge ref_clk_i) disable iff (rst_i)
    (rd_rxl && !sel9lo && count_r == 2'h1 && !push) |=> count_r == 2'h0;
  endproperty
  a_pop_low: assert property (p_pop_low) else $error("low read did not advance");

  property p_hold_high;
    @(posedge ref_clk_i) disable iff (rst_i)
    (rd_rxh && !sel9lo && !push) |=> $stable(count_r);
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("high read advanced");

  property p_rxc_empty;
    @(posedge ref_clk_i) disable iff (rst_i)
    (rd_rxh && count_r == 2'h0) |=> !rdata_o[7];
  endproperty
  a_rxc_empty: assert property (p_rxc_empty) else $error("flag set on empty");

  property p_ovf_set;
    @(posedge ref_clk_i) disable iff (rst_i)
    ovf_set |=> ovf_r;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow missed");

  property p_ovf_clr;
    @(posedge ref_clk_i) disable iff (rst_i)
    (rd_rx && !ovf_set) |=> !ovf_r;
  endproperty
  a_ovf_clr: assert property (p_ovf_clr) else $error("overflow not cleared");

  property p_dre_low;
    @(posedge ref_clk_i) disable iff (rst_i)
    adv |=> !dre ##1 (!dre || $past(tx_if.load));
  endproperty
  a_dre_low: assert property (p_dre_low) else $error("empty flag wrong");

  property p_txc_clr;
    @(posedge ref_clk_i) disable iff (rst_i)
    (txc_clr && !txc_set) |=> !txc_r;
  endproperty
  a_txc_clr: assert property (p_txc_clr) else $error("complete not cleared");

  property p_rsvd_zero;
    @(posedge ref_clk_i) disable iff (rst_i)
    rd_rxh |=> rdata_o[5:3] == 3'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");

  property p_spi_flags;
    @(posedge ref_clk_i) disable iff (rst_i)
    (rd_rxh && spi_host) |=> rdata_o[6:1] == 6'h00;
  endproperty
  a_spi_flags: assert property (p_spi_flags) else $error("flags in host SPI");
endmodule // spdsr_top

// ### spdsr_node.sv
// Remote serial node model: frames onto the receive line, decodes the transmit line
`timescale 1ns/1ps
module spdsr_node #(
  parameter int BAUD = 8
) (
  input  wire logic ref_clk_i,
  input  wire logic txd_i,
  output logic      rxd_o
);
  int         rx_bits = 8;
  logic [8:0] got_q[$];
  logic [8:0] sh;

  // Line idles high between frames
  initial rxd_o = 1'b1;

  // One line bit held a full bit period
  task automatic put(input logic b);
    rxd_o <= b;
    repeat (BAUD) @(posedge ref_clk_i);
  endtask

  // Start, data LSB first, optional parity, one stop bit
  task automatic send(input logic [8:0] d, input int n, input logic pen,
                      input logic pbit, input logic stop);
    @(posedge ref_clk_i);
    put(1'b0);
    for (int i = 0; i < n; i++)
      put(d[i]);
    if (pen)
      put(pbit);
    put(stop);
    rxd_o <= 1'b1;
  endtask

  // Decoder samples mid-bit, parity not expected
  always
  begin
    @(negedge txd_i);
    sh = 9'h000;
    repeat (BAUD / 2) @(posedge ref_clk_i);
    for (int i = 0; i < rx_bits; i++)
    begin
      repeat (BAUD) @(posedge ref_clk_i);
      sh[i] = txd_i;
    end
    repeat (BAUD) @(posedge ref_clk_i);
    got_q.push_back(sh);
  end
endmodule // spdsr_node

// ### serial_port_data_status_regs_test.sv
// Self-checking bench for the serial port data and status registers
`timescale 1ns/1ps
module serial_port_data_status_regs_test;
  localparam int BAUD = 8;
  logic       ref_clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic       lin_pid_field_i = 1'b0;
  logic [7:0] rdata_o;
  logic       rxd_i;
  logic       txd_o;
  logic       irq_rxc_o;
  logic       irq_txc_o;
  logic       irq_dre_o;
  int         bad_count = 0;
  int         n_tests = 0;
  int         seed = 68089;
  logic [8:0] d [0:3];

  spdsr_top dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd_i), .txd_o(txd_o),
    .lin_pid_field_i(lin_pid_field_i), .irq_rxc_o(irq_rxc_o), .irq_txc_o(irq_txc_o),
    .irq_dre_o(irq_dre_o));
  spdsr_node #(.BAUD(BAUD)) node (.ref_clk_i(ref_clk_i), .txd_i(txd_o), .rxd_o(rxd_i));

  // 250 MHz clock
  always #2 ref_clk_i = ~ref_clk_i;

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] dt);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= dt;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input string nm, input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(nm, {1'b0, e}, {1'b0, rdata_o});
  endtask

  task automatic wait_hi(input string nm, ref logic s);
    for (int i = 0; i < 3000 && s !== 1'b1; i++)
      @(posedge ref_clk_i);
    if (s !== 1'b1)
    begin
      $display("FAIL %s expected 1 seen %b", nm, s);
      bad_count++;
      tally_and_finish();
    end
  endtask

  // Non-advancing byte first, then the one that pops
  task automatic rx_pop(input logic nine, input logic [7:0] eh, input logic [7:0] el);
    if (nine)
    begin
      rdc("rx_low", spdsr_pkg::A_RXL, el);
      rdc("rx_high", spdsr_pkg::A_RXH, eh);
    end
    else
    begin
      rdc("rx_high", spdsr_pkg::A_RXH, eh);
      rdc("rx_low", spdsr_pkg::A_RXL, el);
    end
  endtask

  function automatic logic par(input logic [8:0] dt, input int n, input logic odd);
    par = ^(dt & ((9'h001 << n) - 9'h001)) ^ odd;
  endfunction

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge ref_clk_i);
    $display("FAIL run expected end seen hang");
    bad_count++;
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rdc("status", spdsr_pkg::A_STAT, 8'h20);
    rdc("rx_high", spdsr_pkg::A_RXH, 8'h00);
    rdc("unmapped", 4'hF, 8'h00);
    chk("txd", 9'h001, {8'h00, txd_o});
    wr(spdsr_pkg::A_RX_TX_ENABLE_CONTROL, 8'hFF);
    rdc("rx_tx_enable_control", spdsr_pkg::A_RX_TX_ENABLE_CONTROL, 8'hDF);
    wr(spdsr_pkg::A_RXH, 8'hFF);
    rdc("status", spdsr_pkg::A_STAT, 8'h20);
    wr(spdsr_pkg::A_BAUDL, BAUD[7:0]);
    wr(spdsr_pkg::A_BAUDH, 8'h00);
    wr(spdsr_pkg::A_RX_TX_ENABLE_CONTROL, 8'hC0);
    wr(spdsr_pkg::A_FRAME_FORMAT_CONTROL, 8'h03);
    wr(spdsr_pkg::A_INTERRUPT_AND_MODE_CONTROL, 8'hE0);
    chk("irq_dre", 9'h001, {8'h00, irq_dre_o});
    $display("test reset done");
    // Three frames fill buffer and wait stage, a fourth start overflows
    for (int k = 0; k < 3; k++)
    begin
      d[k] = {1'b0, 8'($random(seed))};
      node.send(d[k], 8, 1'b0, 1'b0, 1'b1);
    end
    node.send(9'h0FF, 8, 1'b0, 1'b0, 1'b1);
    wait_hi("irq_rxc", irq_rxc_o);
    rx_pop(1'b0, 8'hC0, d[0][7:0]);
    rx_pop(1'b0, 8'h80, d[1][7:0]);
    rx_pop(1'b0, 8'h80, d[2][7:0]);
    rdc("status", spdsr_pkg::A_STAT, 8'h20);
    $display("test overflow done");
    // Parity even/odd, good/bad, frame error, recovery, then error hidden in host SPI
    for (int k = 0; k < 7; k++)
    begin
      wr(spdsr_pkg::A_FRAME_FORMAT_CONTROL, {{2{k == 6}}, k < 4, k[0], 1'b0, 3'b011});
      d[0] = {1'b0, 8'($random(seed))};
      node.send(d[0], 8, k < 4, par(d[0], 8, k[0]) ^ k[1], k != 4 && k != 6);
      wait_hi("irq_rxc", irq_rxc_o);
      rx_pop(1'b0, {5'b10000, k == 4, k < 4 && k[1], 1'b0}, d[0][7:0]);
    end
    $display("test errors done");
    // Nine-bit, low byte first
    wr(spdsr_pkg::A_FRAME_FORMAT_CONTROL, 8'h06);
    d[0] = 9'($random(seed));
    node.send(d[0], 9, 1'b0, 1'b0, 1'b1);
    wait_hi("irq_rxc", irq_rxc_o);
    rx_pop(1'b1, {7'h40, d[0][8]}, d[0][7:0]);
    rdc("status", spdsr_pkg::A_STAT, 8'h20);
    $display("test nine rx done");
    // Ninth position marks identifier field or response space
    wr(spdsr_pkg::A_FRAME_FORMAT_CONTROL, 8'h03);
    wr(spdsr_pkg::A_RX_TX_ENABLE_CONTROL, 8'hC6);
    for (int k = 0; k < 2; k++)
    begin
      lin_pid_field_i <= k[0];
      d[0] = {1'b0, 8'($random(seed))};
      node.send(d[0], 8, 1'b0, 1'b0, 1'b1);
      wait_hi("irq_rxc", irq_rxc_o);
      rx_pop(1'b0, {7'h40, ~k[0]}, d[0][7:0]);
    end
    wr(spdsr_pkg::A_RX_TX_ENABLE_CONTROL, 8'hC0);
    $display("test lin done");
    // Back-to-back transmit writes while the empty flag is set
    for (int k = 0; k < 2; k++)
      d[k] = {1'b0, 8'($random(seed))};
    wr(spdsr_pkg::A_TXL, d[0][7:0]);
    wr(spdsr_pkg::A_TXL, d[1][7:0]);
    rdc("status", spdsr_pkg::A_STAT, 8'h00);
    chk("irq_dre", 9'h000, {8'h00, irq_dre_o});
    wait_hi("irq_txc", irq_txc_o);
    chk("tx0", d[0], node.got_q[0]);
    chk("tx1", d[1], node.got_q[1]);
    rdc("status", spdsr_pkg::A_STAT, 8'h60);
    wr(spdsr_pkg::A_STAT, 8'h40);
    rdc("status", spdsr_pkg::A_STAT, 8'h20);
    $display("test tx done");
    // Nine-bit transmit: low byte staged, high byte advances
    wr(spdsr_pkg::A_FRAME_FORMAT_CONTROL, 8'h06);
    node.rx_bits = 9;
    node.got_q.delete();
    d[0] = 9'($random(seed));
    wr(spdsr_pkg::A_TXL, d[0][7:0]);
    rdc("status", spdsr_pkg::A_STAT, 8'h20);
    wr(spdsr_pkg::A_TXH, {7'h00, d[0][8]});
    wait_hi("irq_txc", irq_txc_o);
    chk("tx9", d[0], node.got_q[0]);
    $display("test nine tx done");
    // Loop-back: nine-bit frame from the shifter lands in the receive buffer
    wr(spdsr_pkg::A_INTERRUPT_AND_MODE_CONTROL, 8'hE8);
    d[1] = 9'($random(seed));
    wr(spdsr_pkg::A_TXL, d[1][7:0]);
    wr(spdsr_pkg::A_TXH, {7'h00, d[1][8]});
    wait_hi("irq_rxc", irq_rxc_o);
    rx_pop(1'b1, {7'h40, d[1][8]}, d[1][7:0]);
    $display("test loopback done");
    tally_and_finish();
  end
endmodule // serial_port_data_status_regs_test
